// ==== core/ddc_cmd_dec.v ====
`timescale 1ns/10ps
`include "ddc_regs.vh"
module ddc_cmd_dec (
  input  wire        chip_select_n,
  input  wire        row_strobe_n,
  input  wire        column_strobe_n,
  input  wire        write_enable_n,
  input  wire [12:0] addr,
  input  wire        org32,
  output wire [3:0]  cmd,
  output wire        auto_close_bit,
  output wire [9:0]  col
);
  // chip select high overrides every other strobe
  assign cmd = chip_select_n ? `DDC_C_DES :
               {1'b0, row_strobe_n, column_strobe_n, write_enable_n};
  // auto-close line moves with the organisation
  assign auto_close_bit = org32 ? addr[`DDC_ACB_X32] : addr[`DDC_ACB_X16];
  // x32 skips the auto-close line inside the column
  assign col = org32 ? {1'b0, addr[9], addr[7:0]} : addr[9:0];
endmodule // ddc_cmd_dec

// ==== core/ddc_row_mem.v ====
`timescale 1ns/10ps
module ddc_row_mem (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        wr_en,
  input  wire [1:0]  wr_idx,
  input  wire [12:0] wr_row,
  input  wire [1:0]  rd_idx,
  output wire [12:0] rd_row
);
  reg [12:0] mem_ff [0:3];
  reg [12:0] rd_row_ff;
  // array has no reset, rows are only meaningful once opened
  always @(posedge aclk) begin
    if (wr_en) begin
      mem_ff[wr_idx] <= wr_row;
    end
  end
  // registered read port
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_row_ff <= 13'h0;
    end else begin
      rd_row_ff <= mem_ff[rd_idx];
    end
  end
  assign rd_row = rd_row_ff;
endmodule // ddc_row_mem

// ==== core/ddc_top.v ====
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/10ps
`include "ddc_regs.vh"
// Operation
// - pins sampled only at rising clock edge
// - command from select and three strobes
// - unlisted commands or sequences counted illegal
// - deselect and nop both idle
// - auto-close closes bank after its burst
// - auto-close on A8 x32, else A10
// - active latches row; read/write latch column
// - precharge one bank, or all with bit
// - refresh runs, or enters self refresh
// - refresh ignores address, internal counter used
// - bank select picks base or extended config
// - masked data element is not written
// - gate low-low holds, low-high idle exits
// - high-low idle enters precharge/active power-down
// - no config defaults; no power-down before init
// - base config loads with bank select zero
// - base config fields, A8 requests dll reset
module ddc_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        chip_select_n,
  input  wire        row_strobe_n,
  input  wire        column_strobe_n,
  input  wire        write_enable_n,
  input  wire [1:0]  bank_sel,
  input  wire [12:0] addr,
  input  wire        clock_gate_pin,
  input  wire [31:0] dq_in,
  input  wire        dq_strobe,
  input  wire [3:0]  write_byte_mask
);
  localparam PS_RUN = 2'h0;
  localparam PS_PPD = 2'h1;
  localparam PS_APD = 2'h2;
  localparam PS_SRF = 2'h3;
  localparam RP_IDLE = 2'h0;
  localparam RP_MEM  = 2'h1;
  localparam RP_OUT  = 2'h2;
  localparam RP_WAIT = 2'h3;

  wire [3:0]  cmd;
  wire        auto_close_bit;
  wire [9:0]  col;
  wire [3:0]  ac_close;
  wire [31:0] wdat;
  wire [12:0] mem_row;
  wire        bact;
  wire        wr_el;
  wire [2:0]  blc;
  reg         org32_ff;
  reg         cke_prev_ff;
  reg  [1:0]  ps_ff;
  reg  [3:0]  open_ff;
  reg  [12:0] bcfg_ff;
  reg  [12:0] xcfg_ff;
  reg         bok_ff;
  reg         xok_ff;
  reg         dll_ff;
  reg         init_ff;
  reg  [2:0]  bcnt_ff;
  reg         brd_ff;
  reg         bap_ff;
  reg  [1:0]  bbank_ff;
  reg  [9:0]  col_ff;
  reg  [3:0]  lcmd_ff;
  reg  [15:0] ref_cnt_ff;
  reg  [15:0] ill_cnt_ff;
  reg  [15:0] wr_cnt_ff;
  reg  [15:0] msk_cnt_ff;
  reg  [14:0] rpos_ff;
  reg  [1:0]  nxt_ps;
  reg  [3:0]  nxt_open;
  reg         go;
  reg         ill;
  reg         awready_ff;
  reg         wready_ff;
  reg         bvalid_ff;
  reg  [1:0]  bresp_ff;
  reg  [7:0]  wr_addr_ff;
  reg  [31:0] wr_data_ff;
  reg  [3:0]  wr_strb_ff;
  reg         arready_ff;
  reg         rvalid_ff;
  reg  [1:0]  rresp_ff;
  reg  [31:0] rdata_ff;
  reg  [7:0]  rd_addr_ff;
  reg  [1:0]  rph_ff;
  reg  [31:0] rmux;

  // deselect and nop are the same idle command
  function is_idle;
    input [3:0] c;
    begin
      is_idle = (c == `DDC_C_DES) || (c == `DDC_C_NOP);
    end
  endfunction

  // burst length code to clock cycles, two elements a cycle
  function [2:0] bl_cyc;
    input [2:0] code;
    begin
      case (code)
        `DDC_BL4: bl_cyc = `DDC_CYC4;
        `DDC_BL8: bl_cyc = `DDC_CYC8;
        default:  bl_cyc = `DDC_CYC2;
      endcase
    end
  endfunction

  // mapped word check, shared by read and write paths
  function reg_hit;
    input [7:0] a;
    begin
      reg_hit = (a[1:0] == `DDC_ADR_LSB) &&
                ((a <= `DDC_A_WDAT) || ((a & `DDC_ROW_MSK) == `DDC_A_ROW));
    end
  endfunction

  // *****************************************
  // command decode and row memory
  // *****************************************
  // strobes decoded into one command code
  ddc_cmd_dec u_dec (
    .chip_select_n   (chip_select_n),
    .row_strobe_n    (row_strobe_n),
    .column_strobe_n (column_strobe_n),
    .write_enable_n  (write_enable_n),
    .addr            (addr),
    .org32           (org32_ff),
    .cmd             (cmd),
    .auto_close_bit  (auto_close_bit),
    .col             (col)
  );

  // active stores the row of its bank
  ddc_row_mem u_rows (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (go && !ill && (cmd == `DDC_C_ACT)),
    .wr_idx  (bank_sel),
    .wr_row  (addr),
    .rd_idx  (rd_addr_ff[`DDC_IDX_LO+1:`DDC_IDX_LO]),
    .rd_row  (mem_row)
  );

  assign bact  = (bcnt_ff != `DDC_CYC0);
  assign blc   = bl_cyc(bcfg_ff[2:0]);
  assign wr_el = dq_strobe && bact && !brd_ff;

  // *****************************************
  // power state and command legality
  // *****************************************
  // every decision uses the pins at this edge; only the run state also uses the gate level kept from the last one
  always @* begin
    nxt_ps   = ps_ff;
    nxt_open = open_ff & ~ac_close;
    go       = 1'b0;
    ill      = 1'b0;
    case (ps_ff)
      PS_RUN: begin
        if (cke_prev_ff && clock_gate_pin) begin
          go = 1'b1;
          // misuse of a legal code is flagged
          case (cmd)
            `DDC_C_ACT: ill = open_ff[bank_sel];
            `DDC_C_RD, `DDC_C_WR: ill = ~open_ff[bank_sel];
            // terminate only a read without auto-close
            `DDC_C_BST: ill = ~(bact && brd_ff && !bap_ff);
            `DDC_C_REF: ill = |open_ff;
            `DDC_C_LDC: ill = (|open_ff) | bank_sel[1];
            default: ill = 1'b0;
          endcase
        end else if (cke_prev_ff) begin
          // idle at falling gate picks power-down kind
          if (is_idle(cmd) && init_ff) begin
            nxt_ps = (|open_ff) ? PS_APD : PS_PPD;
          // refresh with falling gate enters self refresh
          end else if ((cmd == `DDC_C_REF) && !(|open_ff) && init_ff) begin
            nxt_ps = PS_SRF;
          end else begin
            ill = 1'b1;
          end
        end else begin
          // gate still low since power-up: only idle allowed
          ill = ~is_idle(cmd);
        end
      end
      default: begin
        // low-low holds, low-high with idle exits
        if (clock_gate_pin) begin
          if (is_idle(cmd)) begin
            nxt_ps = PS_RUN;
          end else begin
            ill = 1'b1;
          end
        end
      end
    endcase
    if (go && !ill) begin
      if (cmd == `DDC_C_ACT) begin
        nxt_open[bank_sel] = 1'b1;
      end
      // precharge one bank, or all when bit is high
      if (cmd == `DDC_C_PRE) begin
        if (auto_close_bit) begin
          nxt_open = 4'h0;
        end else begin
          nxt_open[bank_sel] = 1'b0;
        end
      end
    end
  end

  // *****************************************
  // command execution
  // *****************************************
  // config registers hold garbage-free zeros, but init_ff tells truth
  always @(posedge aclk) begin
    if (!aresetn) begin
      cke_prev_ff <= 1'b0;
      ps_ff       <= PS_RUN;
      open_ff     <= 4'h0;
      bcfg_ff     <= 13'h0;
      xcfg_ff     <= 13'h0;
      bok_ff      <= 1'b0;
      xok_ff      <= 1'b0;
      dll_ff      <= 1'b0;
      init_ff     <= 1'b0;
      bbank_ff    <= 2'h0;
      col_ff      <= 10'h0;
      lcmd_ff     <= `DDC_C_DES;
      ref_cnt_ff  <= 16'h0;
      ill_cnt_ff  <= 16'h0;
      rpos_ff     <= 15'h0;
    end else begin
      // previous gate level kept for the next edge
      cke_prev_ff <= clock_gate_pin;
      ps_ff       <= nxt_ps;
      open_ff     <= nxt_open;
      if (ill) begin
        ill_cnt_ff <= ill_cnt_ff + 16'h1;
      end
      if (go && !ill && !is_idle(cmd)) begin
        lcmd_ff <= cmd;
        case (cmd)
          // bank and start column of the burst
          `DDC_C_RD, `DDC_C_WR: begin
            bbank_ff <= bank_sel;
            col_ff   <= col;
          end
          // address ignored, internal counter walks on
          `DDC_C_REF: begin
            ref_cnt_ff <= ref_cnt_ff + 16'h1;
            rpos_ff    <= rpos_ff + 15'h1;
          end
          // bank select picks the config register
          `DDC_C_LDC: begin
            // base register on bank select zero
            if (bank_sel == `DDC_BA_BASE) begin
              bcfg_ff <= addr;
              bok_ff  <= 1'b1;
              if (addr[`DDC_BCFG_DLL]) begin
                dll_ff <= 1'b1;
              // ready once both loaded and a dll reset seen on an earlier base load
              end else if (dll_ff && xok_ff) begin
                init_ff <= 1'b1;
              end
            end else begin
              xcfg_ff <= addr;
              xok_ff  <= 1'b1;
            end
          end
          default: begin
            lcmd_ff <= cmd;
          end
        endcase
      end
    end
  end

  // burst tracker, loaded by read or write
  always @(posedge aclk) begin
    if (!aresetn) begin
      bcnt_ff <= `DDC_CYC0;
      brd_ff  <= 1'b0;
      bap_ff  <= 1'b0;
    end else if (go && !ill && ((cmd == `DDC_C_RD) || (cmd == `DDC_C_WR))) begin
      bcnt_ff <= blc;
      brd_ff  <= (cmd == `DDC_C_RD);
      bap_ff  <= auto_close_bit;
    end else if (go && !ill && (cmd == `DDC_C_BST)) begin
      bcnt_ff <= `DDC_CYC0;
    end else if (bact) begin
      bcnt_ff <= bcnt_ff - `DDC_CYC2;
    end
  end

  // per-bank auto-close timers, so closes overlap across banks
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_bank
      reg [2:0] apc_ff;
      // close this bank as its burst ends
      always @(posedge aclk) begin
        if (!aresetn) begin
          apc_ff <= `DDC_CYC0;
        end else if (go && !ill && auto_close_bit && (bank_sel == g) &&
                     ((cmd == `DDC_C_RD) || (cmd == `DDC_C_WR))) begin
          apc_ff <= blc;
        end else if (apc_ff != `DDC_CYC0) begin
          apc_ff <= apc_ff - `DDC_CYC2;
        end
      end
      assign ac_close[g] = (apc_ff == `DDC_CYC2);
    end
  endgenerate

  // *****************************************
  // write data with byte mask
  // *****************************************
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      reg [7:0] lane_ff;
      // lane kept when its mask is high
      always @(posedge aclk) begin
        if (!aresetn) begin
          lane_ff <= 8'h00;
        end else if (wr_el && !write_byte_mask[g]) begin
          lane_ff <= dq_in[8*g+7:8*g];
        end
      end
      assign wdat[8*g+7:8*g] = lane_ff;
    end
  endgenerate

  // element counts: any lane written, or fully masked
  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_cnt_ff  <= 16'h0;
      msk_cnt_ff <= 16'h0;
    end else if (wr_el) begin
      if (&write_byte_mask) begin
        msk_cnt_ff <= msk_cnt_ff + 16'h1;
      end else begin
        wr_cnt_ff <= wr_cnt_ff + 16'h1;
      end
    end
  end

  // *****************************************
  // register bus slave
  // *****************************************
  // one write at a time; address and data taken in any order
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `DDC_RESP_OK;
      wr_addr_ff <= 8'h00;
      wr_data_ff <= 32'h0;
      wr_strb_ff <= 4'h0;
      org32_ff   <= 1'b0;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        awready_ff <= 1'b0;
        wr_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff) begin
        wready_ff  <= 1'b0;
        wr_data_ff <= s_axi_wdata;
        wr_strb_ff <= s_axi_wstrb;
      end
      if (!awready_ff && !wready_ff && !bvalid_ff) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= reg_hit(wr_addr_ff) ? `DDC_RESP_OK : `DDC_RESP_ERR;
        if ((wr_addr_ff == `DDC_A_CTRL) && wr_strb_ff[0]) begin
          org32_ff <= wr_data_ff[0];
        end
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  // read mux, row window served from the memory port
  always @* begin
    case (rd_addr_ff)
      `DDC_A_CTRL: rmux = {31'h0, org32_ff};
      `DDC_A_STAT: rmux = {21'h0, init_ff, dll_ff, xok_ff, bok_ff, bact, ps_ff, open_ff};
      `DDC_A_BCFG: rmux = {19'h0, bcfg_ff};
      `DDC_A_XCFG: rmux = {19'h0, xcfg_ff};
      `DDC_A_ECNT: rmux = {ill_cnt_ff, ref_cnt_ff};
      `DDC_A_WCNT: rmux = {msk_cnt_ff, wr_cnt_ff};
      `DDC_A_LAST: rmux = {16'h0, lcmd_ff, bbank_ff, col_ff};
      `DDC_A_RPOS: rmux = {17'h0, rpos_ff};
      `DDC_A_WDAT: rmux = wdat;
      default:     rmux = reg_hit(rd_addr_ff) ? {19'h0, mem_row} : 32'h0;
    endcase
  end

  // read answers two edges after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= `DDC_RESP_OK;
      rdata_ff   <= 32'h0;
      rd_addr_ff <= 8'h00;
      rph_ff     <= RP_IDLE;
    end else begin
      case (rph_ff)
        RP_IDLE: begin
          if (s_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rd_addr_ff <= s_axi_araddr;
            rph_ff     <= RP_MEM;
          end
        end
        RP_MEM: rph_ff <= RP_OUT;
        RP_OUT: begin
          rvalid_ff <= 1'b1;
          rdata_ff  <= rmux;
          rresp_ff  <= reg_hit(rd_addr_ff) ? `DDC_RESP_OK : `DDC_RESP_ERR;
          rph_ff    <= RP_WAIT;
        end
        RP_WAIT: begin
          if (s_axi_rready) begin
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b1;
            rph_ff     <= RP_IDLE;
          end
        end
        default: rph_ff <= RP_IDLE;
      endcase
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;
endmodule // ddc_top

// ==== inc/ddc_regs.vh ====
`ifndef DDC_REGS_VH
`define DDC_REGS_VH
// register byte offsets, one aligned word each
`define DDC_A_CTRL 8'h00
`define DDC_A_STAT 8'h04
`define DDC_A_BCFG 8'h08
`define DDC_A_XCFG 8'h0c
`define DDC_A_ECNT 8'h10
`define DDC_A_WCNT 8'h14
`define DDC_A_LAST 8'h18
`define DDC_A_RPOS 8'h1c
`define DDC_A_WDAT 8'h20
// open-row window, four words from here
`define DDC_A_ROW  8'h30
`define DDC_ROW_MSK 8'hf0
`define DDC_IDX_LO 2
`define DDC_ADR_LSB 2'h0
// command codes {ras_n,cas_n,we_n}, deselect apart
`define DDC_C_LDC 4'h0
`define DDC_C_REF 4'h1
`define DDC_C_PRE 4'h2
`define DDC_C_ACT 4'h3
`define DDC_C_WR  4'h4
`define DDC_C_RD  4'h5
`define DDC_C_BST 4'h6
`define DDC_C_NOP 4'h7
`define DDC_C_DES 4'h8
// address fields
`define DDC_ACB_X32 8
`define DDC_ACB_X16 10
`define DDC_BCFG_DLL 8
`define DDC_BA_BASE 2'h0
`define DDC_BL2 3'h1
`define DDC_BL4 3'h2
`define DDC_BL8 3'h3
// burst lengths as clock cycles
`define DDC_CYC2 3'h1
`define DDC_CYC4 3'h2
`define DDC_CYC8 3'h4
`define DDC_CYC0 3'h0
// bus answers
`define DDC_RESP_OK  2'h0
`define DDC_RESP_ERR 2'h2
`endif

// ==== tb/ddc_ctl_model.sv ====
`timescale 1ns/10ps
// ************************************
// memory controller stand-in
// ************************************
module ddc_ctl_model (
  input  wire        aclk,
  output reg         chip_select_n,
  output reg         row_strobe_n,
  output reg         column_strobe_n,
  output reg         write_enable_n,
  output reg  [1:0]  bank_sel,
  output reg  [12:0] addr,
  output reg         clock_gate_pin,
  output reg  [31:0] dq_in,
  output reg         dq_strobe,
  output reg  [3:0]  write_byte_mask
);
  // gate low and idle command until the bench starts
  initial begin
    {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = 4'h7;
    {bank_sel, addr, clock_gate_pin, dq_strobe} = 17'h0;
    {dq_in, write_byte_mask} = 36'h0;
  end
  task go(input [3:0] c, input [1:0] b, input [12:0] a, input g);
    begin
      @(posedge aclk);
      {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} <= c;
      bank_sel <= b;
      addr <= a;
      clock_gate_pin <= g;
    end
  endtask
  // mask travels with its element, gate left high
  task put(input [31:0] d, input [3:0] m);
    begin
      @(posedge aclk);
      {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} <= 4'h7;
      dq_in <= d;
      write_byte_mask <= m;
      dq_strobe <= 1'b1;
    end
  endtask
  // idle after a command; lines turn over so stale values never pass for valid ones
  task rest;
    begin
      @(posedge aclk);
      {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} <= 4'h7;
      addr <= ~addr;
      bank_sel <= ~bank_sel;
      dq_in <= ~dq_in;
      write_byte_mask <= ~write_byte_mask;
      dq_strobe <= 1'b0;
    end
  endtask
endmodule // ddc_ctl_model

// ==== tb/ddc_top_chk.sv ====
`timescale 1ns/10ps
// ************************************
// register bus handshake checks
// ************************************
module ddc_top_chk (
  input wire        aclk,
  input wire        aresetn,
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // unaligned, or past the data word and outside the row window
  function automatic logic unm(input logic [7:0] a);
    unm = (a[1:0] != 2'h0) || (a > 8'h20 && a[7:4] != 4'h3);
  endfunction
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write answer missing");
  a_rd_answer: assert property (s_rd_take |-> ##[1:3] s_axi_rvalid)
    else $error("read answer missing");
  a_wr_block: assert property (s_wr_take |=> !s_axi_awready && !s_axi_wready)
    else $error("write taken twice");
  a_rd_block: assert property (s_rd_take |=> !s_axi_arready)
    else $error("read taken twice");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write answer stuck");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer stuck");
  a_rd_unmapped: assert property (s_rd_take ##0 unm(s_axi_araddr) |-> ##[1:3] s_axi_rvalid &&
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
  a_wr_unmapped: assert property (s_wr_take ##0 unm(s_axi_awaddr) |-> ##[1:2] s_axi_bvalid &&
    s_axi_bresp == 2'h2) else $error("unmapped write accepted");
endmodule // ddc_top_chk
bind ddc_top ddc_top_chk chk_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ==== tb/tb_ddr_sdram_command_interface.sv ====
`timescale 1ns/10ps
`include "ddc_regs.vh"
// ************************************
// command interface bench
// ************************************
module tb_ddr_sdram_command_interface;
  localparam [12:0] BCFG = 13'h0033; // burst of eight, latency three
  localparam        TCW  = 4;        // close_wait_time in clocks
  localparam        TCFG = 2;        // config_load_wait in clocks
  localparam        TXSR = 8;        // refresh_exit_wait in clocks
  reg         aclk    = 1'b0;
  reg         aresetn = 1'b0;
  reg  [7:0]  awaddr  = 8'h0;
  reg  [7:0]  araddr  = 8'h0;
  reg  [31:0] wdata   = 32'h0;
  reg  [3:0]  wstrb   = 4'hf;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire        awready, wready, bvalid, arready, rvalid, cs_n, ras_n, cas_n, we_n, gate, dqs;
  wire [1:0]  bresp, rresp, ba;
  wire [31:0] rdata, dq;
  wire [12:0] a;
  wire [3:0]  bm;
  integer     err_count = 0;
  integer     checks = 0;
  // 50 MHz clock
  always #10 aclk = ~aclk;
  ddc_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .chip_select_n(cs_n),
    .row_strobe_n(ras_n), .column_strobe_n(cas_n), .write_enable_n(we_n), .bank_sel(ba), .addr(a),
    .clock_gate_pin(gate), .dq_in(dq), .dq_strobe(dqs), .write_byte_mask(bm));
  ddc_ctl_model m (.aclk(aclk), .chip_select_n(cs_n), .row_strobe_n(ras_n), .column_strobe_n(cas_n),
    .write_enable_n(we_n), .bank_sel(ba), .addr(a), .clock_gate_pin(gate), .dq_in(dq), .dq_strobe(dqs),
    .write_byte_mask(bm));
  task end_sim;
    begin
      if (err_count == 0 && checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("Error %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tmo;
    begin
      err_count = err_count + 1;
      $display("Error %0t: bus answer timed out", $time);
      end_sim;
    end
  endtask
  // write, ready for the answer from the start
  task axw(input [7:0] ad, input [31:0] d, input [1:0] er);
    integer n;
    begin
      @(posedge aclk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {ad, d, 3'h7};
      n = 0;
      while (!(bvalid === 1'b1 && bready) && n < 40) begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        n = n + 1;
      end
      if (n == 40) tmo;
      cmp({30'h0, bresp}, {30'h0, er});
      bready <= 1'b0;
    end
  endtask
  task axr(input [7:0] ad, input [31:0] ed, input [1:0] er);
    integer n;
    begin
      @(posedge aclk);
      {araddr, arvalid, rready} <= {ad, 2'h3};
      n = 0;
      while (!(rvalid === 1'b1 && rready) && n < 40) begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
        n = n + 1;
      end
      if (n == 40) tmo;
      cmp({30'h0, rresp}, {30'h0, er});
      cmp(rdata, ed);
      rready <= 1'b0;
    end
  endtask
  task c(input [3:0] cd, input [1:0] b, input [12:0] ad);
    begin
      m.go(cd, b, ad, 1'b1);
      m.rest;
    end
  endtask
  task t_init;
    begin
      m.go(`DDC_C_NOP, 2'h0, 13'h0, 1'b1);
      repeat (10000) @(posedge aclk);
      c(`DDC_C_PRE, 2'h0, 13'h400);
      repeat (TCW) @(posedge aclk);
      c(`DDC_C_LDC, 2'h1, 13'h0);
      repeat (TCFG) @(posedge aclk);
      c(`DDC_C_LDC, 2'h0, BCFG | 13'h100);
      repeat (200) @(posedge aclk);
      c(`DDC_C_PRE, 2'h0, 13'h400);
      c(`DDC_C_REF, 2'h0, 13'h0);
      c(`DDC_C_REF, 2'h0, 13'h0);
      c(`DDC_C_LDC, 2'h0, BCFG);
      repeat (TCFG) @(posedge aclk);
      axr(`DDC_A_STAT, 32'h780, 2'h0);
      axr(`DDC_A_BCFG, {19'h0, BCFG}, 2'h0);
      axr(`DDC_A_ECNT, 32'h2, 2'h0);
    end
  endtask
  task t_rowcol;
    begin
      c(`DDC_C_ACT, 2'h1, 13'h0123);
      axr(8'h34, 32'h123, 2'h0);
      c(`DDC_C_RD, 2'h1, 13'h0405);
      axr(`DDC_A_LAST, {16'h0, `DDC_C_RD, 12'h405}, 2'h0);
      axr(`DDC_A_STAT, 32'h780, 2'h0);
      axw(`DDC_A_CTRL, 32'h1, 2'h0);
      axw(8'h24, 32'h1, 2'h2);
      axw(`DDC_A_STAT, 32'hffff, 2'h0);
      axr(8'h40, 32'h0, 2'h2);
      c(`DDC_C_ACT, 2'h2, 13'h0456);
      c(`DDC_C_RD, 2'h2, 13'h0107);
      axr(`DDC_A_LAST, {16'h0, `DDC_C_RD, 12'h807}, 2'h0);
      axr(`DDC_A_STAT, 32'h780, 2'h0);
      c(`DDC_C_ACT, 2'h0, 13'h0);
      c(`DDC_C_ACT, 2'h2, 13'h0);
      c(`DDC_C_PRE, 2'h2, 13'h400);
      axr(`DDC_A_STAT, 32'h781, 2'h0);
      c(`DDC_C_PRE, 2'h3, 13'h100);
      axr(`DDC_A_STAT, 32'h780, 2'h0);
      axw(`DDC_A_CTRL, 32'h0, 2'h0);
    end
  endtask
  task t_ill;
    begin
      c(`DDC_C_BST, 2'h0, 13'h0);
      c(`DDC_C_LDC, 2'h2, 13'h0);
      c(`DDC_C_ACT, 2'h0, 13'h10);
      c(`DDC_C_REF, 2'h0, 13'h0);
      c(`DDC_C_DES, 2'h0, 13'h1ff);
      axr(`DDC_A_BCFG, {19'h0, BCFG}, 2'h0);
      m.go(`DDC_C_RD, 2'h0, 13'h0, 1'b1);
      m.go(`DDC_C_BST, 2'h0, 13'h0, 1'b1);
      m.rest;
      axr(`DDC_A_ECNT, 32'h0003_0002, 2'h0);
      axr(`DDC_A_STAT, 32'h781, 2'h0);
      c(`DDC_C_PRE, 2'h0, 13'h400);
    end
  endtask
  // whole, partial and full masking within one burst
  task t_wr;
    begin
      c(`DDC_C_ACT, 2'h0, 13'h20);
      m.go(`DDC_C_WR, 2'h0, 13'h408, 1'b1);
      m.put(32'h11223344, 4'h0);
      m.put(32'haabbccdd, 4'h5);
      m.put(32'h55667788, 4'hf);
      m.rest;
      axr(`DDC_A_WCNT, 32'h0001_0002, 2'h0);
      axr(`DDC_A_WDAT, 32'haa22cc44, 2'h0);
      axr(`DDC_A_STAT, 32'h780, 2'h0);
    end
  endtask
  task t_pwr;
    begin
      c(`DDC_C_ACT, 2'h1, 13'h0);
      m.go(`DDC_C_NOP, 2'h0, 13'h0, 1'b0);
      axr(`DDC_A_STAT, 32'h7a2, 2'h0);
      m.go(`DDC_C_NOP, 2'h0, 13'h0, 1'b1);
      axr(`DDC_A_STAT, 32'h782, 2'h0);
      c(`DDC_C_PRE, 2'h0, 13'h400);
      m.go(`DDC_C_NOP, 2'h0, 13'h0, 1'b0);
      axr(`DDC_A_STAT, 32'h790, 2'h0);
      m.go(`DDC_C_NOP, 2'h0, 13'h0, 1'b1);
      c(`DDC_C_REF, 2'h3, 13'h1fff);
      axr(`DDC_A_RPOS, 32'h3, 2'h0);
      m.go(`DDC_C_REF, 2'h0, 13'h0, 1'b0);
      m.rest;
      axr(`DDC_A_STAT, 32'h7b0, 2'h0);
      m.go(`DDC_C_NOP, 2'h0, 13'h0, 1'b1);
      repeat (TXSR) @(posedge aclk);
      axr(`DDC_A_STAT, 32'h780, 2'h0);
      axr(`DDC_A_ECNT, 32'h0003_0003, 2'h0);
    end
  endtask
  // reset, then each scenario in turn
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_init;
    t_rowcol;
    t_ill;
    t_wr;
    t_pwr;
    end_sim;
  end
endmodule // tb_ddr_sdram_command_interface
